// File: rtl/cdcrg_pkg.sv
// Package for the converter control register bank.
// Assumes an 8-bit register port with 7-bit addresses from the control port.
package cdcrg_pkg;
   // Register addresses
   localparam logic [6:0] ADDR_ZERO_PIN_FUNC  = 7'h67;
   localparam logic [6:0] ADDR_DAC_LEFT_VOL   = 7'h68;
   localparam logic [6:0] ADDR_DAC_RIGHT_VOL  = 7'h69;
   localparam logic [6:0] ADDR_DAC_LEFT_PEAK  = 7'h6a;
   localparam logic [6:0] ADDR_DAC_RIGHT_PEAK = 7'h6b;
   localparam logic [6:0] ADDR_ADC_LEFT_GAIN  = 7'h6c;
   localparam logic [6:0] ADDR_ADC_RIGHT_GAIN = 7'h6d;
   localparam logic [6:0] ADDR_ADC_CTRL_PRI   = 7'h6e;
   localparam logic [6:0] ADDR_ADC_CTRL_SEC   = 7'h6f;
   // Field positions
   localparam int POS_IRQ_SEL    = 6;
   localparam int POS_RSEL_LO    = 4;
   localparam int POS_MOD_CLK    = 7;
   localparam int POS_HPF        = 6;
   localparam int POS_CONV_OFF   = 5;
   localparam int POS_ANA_OFF    = 4;
   localparam int POS_RSIL       = 3;
   localparam int POS_LSIL       = 2;
   localparam int POS_PGA_L_OFF  = 1;
   localparam int POS_PGA_R_OFF  = 0;
   localparam int POS_REFBUF_OFF = 4;
   localparam int POS_MDIV_LO    = 0;
   // Writable bit masks, reserved bits are held at zero
   localparam logic [7:0] MASK_ZERO_PIN = 8'h70;
   localparam logic [7:0] MASK_GAIN     = 8'h3f;
   localparam logic [7:0] MASK_CTRL_SEC = 8'h13;
   // Reset values
   localparam logic [7:0] RST_ZERO_PIN  = 8'h00;
   localparam logic [7:0] RST_VOL       = 8'hff;
   localparam logic [7:0] RST_GAIN      = 8'h00;
   localparam logic [7:0] RST_CTRL_PRI  = 8'h00;
   localparam logic [7:0] RST_CTRL_SEC  = 8'h00;
   // Right pin function codes
   localparam logic [1:0] RSEL_RIGHT = 2'h0;
   localparam logic [1:0] RSEL_LEFT  = 2'h1;
   localparam logic [1:0] RSEL_ANY   = 2'h2;
   localparam logic [1:0] RSEL_BOTH  = 2'h3;
   // Gain limit and master clock divider codes
   localparam logic [5:0] PGA_MAX_CODE = 6'h30;
   localparam logic [1:0] MDIV_DIV3    = 2'h2;
   localparam logic [1:0] MDIV_DIV2    = 2'h1;
endpackage

// File: rtl/cdcrg_zero_pins.sv
// Zero flag pin function and polarity logic.
// Assumes zero flags arrive already synchronised to ref_clk.
`timescale 1ns/100ps
module cdcrg_zero_pins
   import cdcrg_pkg::*;
(
   input  wire logic       ref_clk,         // System clock
   input  wire logic       rstn,            // Async reset, active low
   input  wire logic       left_zero,       // Left channel zero, high true
   input  wire logic       right_zero,      // Right channel zero, high true
   input  wire logic       irq_req,         // Interrupt request, high true
   input  wire logic       left_pin_irq_select,       // Left pin role
   input  wire logic [1:0] right_pin_function_select, // Right pin role
   input  wire logic       zero_flag_polarity,        // 1 active high
   output logic            left_zero_pin,   // Combined left/interrupt pin
   output logic            right_zero_pin   // Right zero pin
);
   logic left_d, left_q, right_d, right_q;

   // Pin function select
   always_comb begin
      if (left_pin_irq_select) begin
         left_d = irq_req;                                       // [RULE1]
         case (right_pin_function_select)
            RSEL_RIGHT: right_d = right_zero;                    // [RULE2]
            RSEL_LEFT:  right_d = left_zero;                     // [RULE2]
            RSEL_ANY:   right_d = left_zero | right_zero;        // [RULE3]
            RSEL_BOTH:  right_d = left_zero & right_zero;        // [RULE3]
            default:    right_d = right_zero;
         endcase
      end else begin
         left_d  = left_zero;                                    // [RULE1]
         right_d = right_zero;
      end
   end

   // Registered pin levels
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         left_q  <= 1'b0;
         right_q <= 1'b0;
      end else begin
         left_q  <= left_d;
         right_q <= right_d;
      end
   end

   // Polarity: inverted when active low
   assign left_zero_pin  = left_q ^ ~zero_flag_polarity;         // [RULE13]
   assign right_zero_pin = right_q ^ ~zero_flag_polarity;        // [RULE13]
endmodule

// File: rtl/cdcrg_clk_div.sv
// Record master clock divider and modulator clock enable generator.
// Produces one-cycle strobes on ref_clk standing for the divided clocks.
`timescale 1ns/100ps
module cdcrg_clk_div
   import cdcrg_pkg::*;
(
   input  wire logic       ref_clk,     // System clock, the ADC master clock
   input  wire logic       rstn,        // Async reset, active low
   input  wire logic [1:0] record_master_clock_divider, // Divider code
   input  wire logic       modulator_clock_select,      // 0 div2, 1 div4
   output logic            mclk_tick,   // Divided master clock strobe
   output logic            mod_tick     // Modulator clock strobe
);
   logic [1:0] mdiv_d, mdiv_q;
   logic [1:0] mod_d, mod_q;
   logic [1:0] mdiv_top;
   logic       mtick_d, mtick_q, otick_d, otick_q;

   // Next divider counts
   always_comb begin
      case (record_master_clock_divider)                         // [RULE12]
         MDIV_DIV2: mdiv_top = 2'h1;
         MDIV_DIV3: mdiv_top = 2'h2;
         default:  mdiv_top = 2'h0;
      endcase
      mtick_d = (mdiv_q >= mdiv_top);
      mdiv_d  = mtick_d ? 2'h0 : mdiv_q + 2'h1;
      mod_d   = mod_q;
      otick_d = 1'b0;
      if (mtick_d) begin
         mod_d = mod_q + 2'h1;
         // Half or quarter rate of divided master clock
         otick_d = modulator_clock_select ? (mod_q == 2'h3)
                                          : mod_q[0];            // [RULE8]
      end
   end

   // Divider registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mdiv_q  <= 2'h0;
         mod_q   <= 2'h0;
         mtick_q <= 1'b0;
         otick_q <= 1'b0;
      end else begin
         mdiv_q  <= mdiv_d;
         mod_q   <= mod_d;
         mtick_q <= mtick_d;
         otick_q <= otick_d;
      end
   end

   assign mclk_tick = mtick_q;
   assign mod_tick  = otick_q;
endmodule

// File: rtl/cdcrg_regs.sv
// Control and status register bank for playback and record converters.
// Assumes the serial control port delivers decoded 8-bit register
// accesses on ref_clk; peak levels and zero flags come from pins.
// Function
// [RULE1] Left pin select 0 gives the left zero flag, 1 gives interrupt.
// [RULE2] In interrupt mode right pin code 00 gives right, 01 left flag.
// [RULE3] Right pin code 10 means either channel zero, 11 means both.
// [RULE4] Left volume all ones is 0 dBFS, each step down is 0.375 dB.
// [RULE5] Right volume uses the same encoding as the left volume.
// [RULE6] Peak fields report 1 dB steps, 0 is 0 dBFS, 63 is -63 or below.
// [RULE7] Input gains step 0.5 dB to 24 dB at 110000 and saturate above.
// [RULE8] Modulator clock bit 0 divides by 2, 1 divides by 4.
// [RULE9] Converter and analog power-down bits at 1 power down the ADC.
// [RULE10] Record silence bits at 1 mute, opposite to playback mutes.
// [RULE11] Reference buffer bit at 1 shuts the buffer down.
// [RULE12] Master clock divider codes 00, 01, 10, 11 divide 1, 2, 3, 1.
// [RULE13] Zero flag pins are active low at polarity 0, high at 1.
// [RULE14] Software writes zero to reserved bits and ignores them on read.
`timescale 1ns/100ps
module cdcrg_regs
   import cdcrg_pkg::*;
(
   input  wire logic       ref_clk,      // 25 MHz system clock
   input  wire logic       rstn,         // Async reset, active low
   input  wire logic [6:0] reg_addr,     // Register address
   input  wire logic       reg_wr,       // Write strobe
   input  wire logic [7:0] reg_wdata,    // Write data
   input  wire logic       reg_rd,       // Read strobe
   output logic      [7:0] reg_rdata,    // Read data, registered
   input  wire logic [5:0] peak_left_in, // Left peak level from detector
   input  wire logic [5:0] peak_right_in,// Right peak level from detector
   input  wire logic       left_zero,    // Left channel zero, pin input
   input  wire logic       right_zero,   // Right channel zero, pin input
   input  wire logic       irq_req,      // Interrupt source, pin input
   input  wire logic       zero_flag_polarity, // Polarity bit, 1 high
   output logic            left_zero_pin,      // Combined left/irq pin
   output logic            right_zero_pin,     // Right zero pin
   output logic      [7:0] playback_left_gain, // Left DAC attenuation
   output logic      [7:0] playback_right_gain,// Right DAC attenuation
   output logic      [5:0] input_left_gain,    // Left PGA gain, saturated
   output logic      [5:0] input_right_gain,   // Right PGA gain, saturated
   output logic            hpf_enable,          // High-pass filter on
   output logic            record_converter_off,// Whole ADC power-down
   output logic            record_analog_off,   // ADC analog power-down
   output logic            record_left_silence, // Left record mute
   output logic            record_right_silence,// Right record mute
   output logic            pga_left_off,        // Left PGA power-down
   output logic            pga_right_off,       // Right PGA power-down
   output logic            reference_buffer_off,// Reference buffer off
   output logic            mclk_tick,           // Divided master clock
   output logic            mod_tick             // Modulator clock strobe
);
   logic [7:0] zpin_d, zpin_q;
   logic [7:0] lvol_d, lvol_q, rvol_d, rvol_q;
   logic [7:0] lgain_d, lgain_q, rgain_d, rgain_q;
   logic [7:0] cpri_d, cpri_q, csec_d, csec_q;
   logic [7:0] rdata_d, rdata_q;
   logic [5:0] lpk_s1, lpk_s2, rpk_s1, rpk_s2;
   logic [2:0] zin_s1, zin_s2;
   logic       zpol_s1, zpol_s2;

   // Clamp a gain code to the 24 dB ceiling
   function automatic logic [5:0] sat_gain(input logic [7:0] code);
      sat_gain = (code[5:0] > PGA_MAX_CODE) ? PGA_MAX_CODE
                                            : code[5:0];         // [RULE7]
   endfunction

   // Register writes with reserved bits masked
   always_comb begin
      zpin_d  = zpin_q;
      lvol_d  = lvol_q;
      rvol_d  = rvol_q;
      lgain_d = lgain_q;
      rgain_d = rgain_q;
      cpri_d  = cpri_q;
      csec_d  = csec_q;
      if (reg_wr) begin
         case (reg_addr)
            ADDR_ZERO_PIN_FUNC:  zpin_d  = reg_wdata & MASK_ZERO_PIN;
            ADDR_DAC_LEFT_VOL:   lvol_d  = reg_wdata;           // [RULE4]
            ADDR_DAC_RIGHT_VOL:  rvol_d  = reg_wdata;           // [RULE5]
            ADDR_ADC_LEFT_GAIN:  lgain_d = reg_wdata & MASK_GAIN;
            ADDR_ADC_RIGHT_GAIN: rgain_d = reg_wdata & MASK_GAIN;
            ADDR_ADC_CTRL_PRI:   cpri_d  = reg_wdata;
            ADDR_ADC_CTRL_SEC:   csec_d  = reg_wdata & MASK_CTRL_SEC;
            default:             zpin_d  = zpin_q;
         endcase
      end
   end

   // Read data mux, peak levels from synchronised inputs
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_ZERO_PIN_FUNC:  rdata_d = zpin_q;
            ADDR_DAC_LEFT_VOL:   rdata_d = lvol_q;
            ADDR_DAC_RIGHT_VOL:  rdata_d = rvol_q;
            ADDR_DAC_LEFT_PEAK:  rdata_d = {2'b00, lpk_s2};     // [RULE6]
            ADDR_DAC_RIGHT_PEAK: rdata_d = {2'b00, rpk_s2};     // [RULE6]
            ADDR_ADC_LEFT_GAIN:  rdata_d = lgain_q;
            ADDR_ADC_RIGHT_GAIN: rdata_d = rgain_q;
            ADDR_ADC_CTRL_PRI:   rdata_d = cpri_q;
            ADDR_ADC_CTRL_SEC:   rdata_d = csec_q;
            default:             rdata_d = 8'h00;
         endcase
      end
   end

   // Register state
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         zpin_q  <= RST_ZERO_PIN;
         lvol_q  <= RST_VOL;
         rvol_q  <= RST_VOL;
         lgain_q <= RST_GAIN;
         rgain_q <= RST_GAIN;
         cpri_q  <= RST_CTRL_PRI;
         csec_q  <= RST_CTRL_SEC;
         rdata_q <= 8'h00;
      end else begin
         zpin_q  <= zpin_d;
         lvol_q  <= lvol_d;
         rvol_q  <= rvol_d;
         lgain_q <= lgain_d;
         rgain_q <= rgain_d;
         cpri_q  <= cpri_d;
         csec_q  <= csec_d;
         rdata_q <= rdata_d;
      end
   end

   // Two-stage synchronisers for pin inputs
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         lpk_s1  <= 6'h00;
         lpk_s2  <= 6'h00;
         rpk_s1  <= 6'h00;
         rpk_s2  <= 6'h00;
         zin_s1  <= 3'h0;
         zin_s2  <= 3'h0;
         zpol_s1 <= 1'b0;
         zpol_s2 <= 1'b0;
      end else begin
         lpk_s1  <= peak_left_in;
         lpk_s2  <= lpk_s1;
         rpk_s1  <= peak_right_in;
         rpk_s2  <= rpk_s1;
         zin_s1  <= {irq_req, right_zero, left_zero};
         zin_s2  <= zin_s1;
         zpol_s1 <= zero_flag_polarity;
         zpol_s2 <= zpol_s1;
      end
   end

   assign reg_rdata = rdata_q;

   // Control outputs decoded from register fields
   assign playback_left_gain   = lvol_q;                         // [RULE4]
   assign playback_right_gain  = rvol_q;                         // [RULE5]
   assign input_left_gain      = sat_gain(lgain_q);              // [RULE7]
   assign input_right_gain     = sat_gain(rgain_q);              // [RULE7]
   assign hpf_enable           = cpri_q[POS_HPF];
   assign record_converter_off = cpri_q[POS_CONV_OFF];           // [RULE9]
   assign record_analog_off    = cpri_q[POS_ANA_OFF];            // [RULE9]
   assign record_right_silence = cpri_q[POS_RSIL];               // [RULE10]
   assign record_left_silence  = cpri_q[POS_LSIL];               // [RULE10]
   assign pga_left_off         = cpri_q[POS_PGA_L_OFF];
   assign pga_right_off        = cpri_q[POS_PGA_R_OFF];
   assign reference_buffer_off = csec_q[POS_REFBUF_OFF];         // [RULE11]

   // Zero and interrupt pin logic
   cdcrg_zero_pins u_zero_pins (
      .ref_clk                   (ref_clk),
      .rstn                      (rstn),
      .left_zero                 (zin_s2[0]),
      .right_zero                (zin_s2[1]),
      .irq_req                   (zin_s2[2]),
      .left_pin_irq_select       (zpin_q[POS_IRQ_SEL]),
      .right_pin_function_select (zpin_q[POS_RSEL_LO +: 2]),
      .zero_flag_polarity        (zpol_s2),
      .left_zero_pin             (left_zero_pin),
      .right_zero_pin            (right_zero_pin)
   );

   // Record clock dividers
   cdcrg_clk_div u_clk_div (
      .ref_clk                     (ref_clk),
      .rstn                        (rstn),
      .record_master_clock_divider (csec_q[POS_MDIV_LO +: 2]),
      .modulator_clock_select      (cpri_q[POS_MOD_CLK]),
      .mclk_tick                   (mclk_tick),
      .mod_tick                    (mod_tick)
   );
endmodule

// File: test/cdcrg_regs_asserts.sv
// Checker for the converter control register bank.
// Sees only the top module ports; bound in below the module.
`timescale 1ns/100ps
module cdcrg_regs_asserts
   import cdcrg_pkg::*;
(
   input  wire logic       ref_clk,             // System clock
   input  wire logic       rstn,                // Async reset, active low
   input  wire logic [6:0] reg_addr,            // Register address
   input  wire logic       reg_wr,              // Write strobe
   input  wire logic [7:0] reg_wdata,           // Write data
   input  wire logic       reg_rd,              // Read strobe
   input  wire logic [7:0] reg_rdata,           // Read data
   input  wire logic [5:0] peak_left_in,        // Left peak code
   input  wire logic       left_zero,           // Left zero flag
   input  wire logic       irq_req,             // Interrupt source
   input  wire logic       zero_flag_polarity,  // Pin polarity
   input  wire logic       left_zero_pin,       // Left or interrupt pin
   input  wire logic [7:0] playback_left_gain,  // Left volume
   input  wire logic [7:0] playback_right_gain, // Right volume
   input  wire logic [5:0] input_left_gain,     // Left input gain
   input  wire logic       mclk_tick            // Divided clock strobe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic       irq_q, irq_d;
   logic [1:0] dsel_q, dsel_d;
   logic [7:0] quiet_q, quiet_d, gap_q, gap_d;
   // Shadows of pin role and divider, tick spacing counter
   always_comb begin
      irq_d   = irq_q;
      dsel_d  = dsel_q;
      quiet_d = (quiet_q == 8'hff) ? quiet_q : quiet_q + 8'h01;
      gap_d   = mclk_tick ? 8'h01 : gap_q + 8'h01;
      if (reg_wr && reg_addr == ADDR_ZERO_PIN_FUNC)
         irq_d = reg_wdata[6];
      if (reg_wr && reg_addr == ADDR_ADC_CTRL_SEC) begin
         dsel_d  = reg_wdata[1:0];
         quiet_d = 8'h00;
      end
   end
   // Helper registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_q   <= 1'b0;
         dsel_q  <= 2'h0;
         quiet_q <= 8'h00;
         gap_q   <= 8'h00;
      end else begin
         irq_q   <= irq_d;
         dsel_q  <= dsel_d;
         quiet_q <= quiet_d;
         gap_q   <= gap_d;
      end
   end
   // Pin inputs settled through the synchronisers
   sequence s_pins_quiet;
      (!reg_wr && $stable({left_zero, irq_req, zero_flag_polarity}))[*5];
   endsequence
   // Peak code held steady, then read
   sequence s_peak_read;
      ($stable(peak_left_in))[*4] ##0
         (reg_rd && reg_addr == ADDR_DAC_LEFT_PEAK);
   endsequence
   a_left_volume: assert property (
      reg_wr && reg_addr == ADDR_DAC_LEFT_VOL |=>
      playback_left_gain == $past(reg_wdata)) else $error("left volume");
   a_right_volume: assert property (
      reg_wr && reg_addr == ADDR_DAC_RIGHT_VOL |=>
      playback_right_gain == $past(reg_wdata)) else $error("right volume");
   a_left_readback: assert property (
      reg_rd && reg_addr == ADDR_DAC_LEFT_VOL |=>
      reg_rdata == $past(playback_left_gain)) else $error("volume read");
   a_gain_saturate: assert property (
      reg_wr && reg_addr == ADDR_ADC_LEFT_GAIN |=> input_left_gain ==
      (($past(reg_wdata[5:0]) > PGA_MAX_CODE) ? PGA_MAX_CODE :
      $past(reg_wdata[5:0]))) else $error("left gain");
   a_peak_readback: assert property (
      s_peak_read |=> reg_rdata == {2'h0, $past(peak_left_in)})
      else $error("peak read");
   a_mclk_period: assert property (
      mclk_tick && quiet_q > 8'h1e |-> gap_q == ((dsel_q == MDIV_DIV3) ?
      8'h03 : (dsel_q == MDIV_DIV2) ? 8'h02 : 8'h01)) else $error("divider");
   a_left_pin_role: assert property (
      s_pins_quiet |-> left_zero_pin == ((irq_q ? irq_req : left_zero)
      ^ ~zero_flag_polarity)) else $error("left pin");
   a_unmapped_read: assert property (
      reg_rd && (reg_addr < ADDR_ZERO_PIN_FUNC || reg_addr > ADDR_ADC_CTRL_SEC)
      |=> reg_rdata == 8'h00) else $error("unmapped read");
endmodule

bind cdcrg_regs cdcrg_regs_asserts i_cdcrg_regs_asserts (
   .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .peak_left_in(peak_left_in), .left_zero(left_zero), .irq_req(irq_req),
   .zero_flag_polarity(zero_flag_polarity), .left_zero_pin(left_zero_pin),
   .playback_left_gain(playback_left_gain),
   .playback_right_gain(playback_right_gain),
   .input_left_gain(input_left_gain), .mclk_tick(mclk_tick));

// File: test/cdcrg_regs_tb.sv
// Self-checking bench for the converter control register bank.
// Drives every input at the falling edge; the checker is bound in.
`timescale 1ns/100ps
module cdcrg_regs_tb
   import cdcrg_pkg::*;
   ;
   logic       ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic       left_zero = 1'b0, right_zero = 1'b0, irq_req = 1'b0;
   logic       zero_flag_polarity = 1'b0, left_zero_pin, right_zero_pin;
   logic       hpf_enable, record_converter_off, record_analog_off;
   logic       record_left_silence, record_right_silence, pga_left_off;
   logic       pga_right_off, reference_buffer_off, mclk_tick, mod_tick;
   logic [6:0] reg_addr = 7'h00, wa;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, wd, mdl [8'h67:8'h6f];
   logic [7:0] playback_left_gain, playback_right_gain;
   logic [5:0] peak_left_in = 6'h00, peak_right_in = 6'h00;
   logic [5:0] input_left_gain, input_right_gain;
   logic [14:0] corner [12] = '{{7'h68, 8'h00}, {7'h69, 8'hfe},
      {7'h6c, 8'h30}, {7'h6c, 8'h31}, {7'h6d, 8'h3f}, {7'h6d, 8'h2f},
      {7'h6e, 8'hff}, {7'h6e, 8'h00}, {7'h6f, 8'hff}, {7'h67, 8'hff},
      {7'h6a, 8'h55}, {7'h70, 8'haa}};
   int         err_count = 0, compares = 0, seed = 27308, n;

   // Design under test
   cdcrg_regs i_cdcrg_regs (.ref_clk(ref_clk), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .peak_left_in(peak_left_in),
      .peak_right_in(peak_right_in), .left_zero(left_zero),
      .right_zero(right_zero), .irq_req(irq_req),
      .zero_flag_polarity(zero_flag_polarity), .left_zero_pin(left_zero_pin),
      .right_zero_pin(right_zero_pin), .hpf_enable(hpf_enable),
      .playback_left_gain(playback_left_gain), .mod_tick(mod_tick),
      .playback_right_gain(playback_right_gain), .mclk_tick(mclk_tick),
      .input_left_gain(input_left_gain), .input_right_gain(input_right_gain),
      .record_converter_off(record_converter_off),
      .record_analog_off(record_analog_off), .pga_left_off(pga_left_off),
      .record_left_silence(record_left_silence), .pga_right_off(pga_right_off),
      .record_right_silence(record_right_silence),
      .reference_buffer_off(reference_buffer_off));

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;

   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Writable bits of each register, none where unmapped or read-only
   function automatic logic [7:0] msk(logic [6:0] a);
      case (a)
         ADDR_ZERO_PIN_FUNC: return 8'h70;
         ADDR_DAC_LEFT_VOL, ADDR_DAC_RIGHT_VOL: return 8'hff;
         ADDR_ADC_CTRL_PRI: return 8'hff;
         ADDR_ADC_LEFT_GAIN, ADDR_ADC_RIGHT_GAIN: return 8'h3f;
         ADDR_ADC_CTRL_SEC: return 8'h13;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] rexp(logic [6:0] a);
      if (a == ADDR_DAC_LEFT_PEAK) return {2'h0, peak_left_in};
      if (a == ADDR_DAC_RIGHT_PEAK) return {2'h0, peak_right_in};
      return (msk(a) == 8'h00) ? 8'h00 : mdl[a];
   endfunction
   function automatic logic [7:0] sat(logic [7:0] v);
      return (v > 8'h30) ? 8'h30 : v;
   endfunction
   function automatic logic [7:0] div(logic [1:0] c);
      return (c == 2'h2) ? 8'h03 : (c == 2'h1) ? 8'h02 : 8'h01;
   endfunction
   // Expected {left, right} pin levels for role bits {irq, select}
   function automatic logic [1:0] pins(logic [2:0] s);
      logic l, r;
      l = s[2] ? irq_req : left_zero;
      r = (s == 3'h5) ? left_zero : right_zero;
      if (s == 3'h6) r = left_zero | right_zero;
      if (s == 3'h7) r = left_zero & right_zero;
      return {l, r} ^ {2{~zero_flag_polarity}};
   endfunction
   task automatic wr(logic [6:0] a, logic [7:0] d);
      if (msk(a) != 8'h00) d = d & msk(a);
      @(negedge ref_clk);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge ref_clk);
      reg_wr = 1'b0;
      if (msk(a) != 8'h00) mdl[a] = d & msk(a);
   endtask
   task automatic rd(logic [6:0] a);
      @(negedge ref_clk);
      {reg_rd, reg_addr} = {1'b1, a};
      @(negedge ref_clk);
      reg_rd = 1'b0;
      chk("read data", rexp(a), reg_rdata);
   endtask
   task automatic outs();
      chk("left vol", mdl[8'h68], playback_left_gain);
      chk("right vol", mdl[8'h69], playback_right_gain);
      chk("left gain", sat(mdl[8'h6c]), {2'h0, input_left_gain});
      chk("right gain", sat(mdl[8'h6d]), {2'h0, input_right_gain});
      chk("record ctl", {1'b0, mdl[8'h6e][6:0]}, {1'b0, hpf_enable,
         record_converter_off, record_analog_off, record_right_silence,
         record_left_silence, pga_left_off,
         pga_right_off});
      chk("buffer", {7'h0, mdl[8'h6f][4]},
         {7'h0, reference_buffer_off});
   endtask
   // Cycles from one strobe to the next, counted at falling edges
   task automatic gap(logic m, output int g);
      g = 0;
      for (int i = 0; i < 40 && (m ? mod_tick : mclk_tick) !== 1'b1; i++)
         @(negedge ref_clk);
      do begin
         @(negedge ref_clk);
         g++;
      end while ((m ? mod_tick : mclk_tick) !== 1'b1 && g < 40);
   endtask
   task automatic rst_chk();
      for (int a = 8'h67; a <= 8'h6f; a++) mdl[a] = 8'h00;
      mdl[8'h68] = 8'hff;
      mdl[8'h69] = 8'hff;
      outs();
      for (logic [7:0] a = 8'h64; a <= 8'h72; a++) rd(a[6:0]);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(negedge ref_clk);
      rstn = 1'b1;
      rst_chk();
      for (int i = 0; i < 72; i++) begin
         n = $unsigned($random(seed)) % 11;
         {peak_left_in, peak_right_in} = 12'($random(seed));
         repeat (4) @(negedge ref_clk);
         wa = (i < 12) ? corner[i][14:8] : 7'h66 + 7'(n);
         wd = (i < 12) ? corner[i][7:0] : 8'($random(seed));
         wr(wa, wd);
         outs();
         rd(wa);
      end
      for (int k = 0; k < 128; k++) begin
         wr(ADDR_ZERO_PIN_FUNC, {1'b0, 3'(k), 4'h0});
         {zero_flag_polarity, left_zero, right_zero, irq_req} = 4'(k >> 3);
         repeat (5) @(negedge ref_clk);
         chk("zero pins", {6'h0, pins(3'(k))},
            {6'h0, left_zero_pin, right_zero_pin});
      end
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_ADC_CTRL_PRI, {k[2], 7'h00});
         wr(ADDR_ADC_CTRL_SEC, {6'h0, k[1:0]});
         repeat (30) @(negedge ref_clk);
         gap(1'b0, n);
         chk("clock gap", div(k[1:0]), 8'(n));
         gap(1'b1, n);
         chk("mod gap", div(k[1:0]) << (k[2] ? 2 : 1), 8'(n));
      end
      rstn = 1'b0;
      repeat (3) @(negedge ref_clk);
      rstn = 1'b1;
      rst_chk();
      stop_test();
   end

   // Watchdog
   initial begin
      #(40 * 20000);
      err_count++;
      stop_test();
   end
endmodule
